// ### aspirc_core.sv
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps

// What this block does
// - Divisor is 16-bit integer plus 6-bit fraction.
// - Tick at sixteen times baud, bit every 16.
// - Divisor and line settings load on line write.
// - Start, data LSB first, parity, stop bits.
// - Five to eight bits, parity kinds, stop count.
// - Sixteen-entry FIFOs; receive adds four status bits.
// - Enabled port sends frames until FIFO empties.
// - Busy from FIFO non-empty until stop sent.
// - Falling input starts counter, check eighth tick.
// - High at check means false start, idle.
// - Data sampled every sixteenth tick, then parity.
// - Low stop sample flags a framing error.
// - Characters stored with overrun, parity, framing, break.
// - Transmit and receive enables, both set after reset.
// - Disabling finishes the current character first.
// - Normal infrared: zero is 3/16 high pulse.
// - Low-power infrared pulse is three divider periods.
// - Low-power divider divides by 1 to 256.
// - Infrared low input is a pulse, decoded onward.
module aspirc_core #(
  parameter int DEPTH = 16 // Entries in each FIFO.
) (
  input wire logic clk_sys, // System clock, 25 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB access phase.
  input wire logic pwrite, // APB direction, high for write.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data, from a flop.
  output logic pready, // APB ready, always high.
  output logic pslverr, // APB error for unmapped address.
  input wire logic serialInPin, // Serial or infrared receive line.
  output logic serialOutPin // Serial or infrared transmit line.
);

  localparam int AW = $clog2(DEPTH); // FIFO index width; pointers are one bit wider.

  // Counts entries in a FIFO from its two wrapping pointers.
  function automatic logic [AW:0] fill(input logic [AW:0] wr, input logic [AW:0] rd);
    fill = wr - rd;
  endfunction

  // Register bus decode. Reads are staged in the setup cycle, so no wait state is needed.
  logic setupRd; // Read setup cycle.
  logic accWr; // Write access cycle.
  logic accRd; // Read access cycle.
  logic mapped; // Address hits a register.
  assign setupRd = psel && !penable && !pwrite;
  assign accWr = psel && penable && pwrite;
  assign accRd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign mapped = paddr inside {aspirc_pkg::OFF_DATA, aspirc_pkg::OFF_RXSTAT,
    aspirc_pkg::OFF_FLAG, aspirc_pkg::OFF_LPDIV, aspirc_pkg::OFF_DIVINT,
    aspirc_pkg::OFF_DIVISOR_FRACTION_FIELD, aspirc_pkg::OFF_LINE, aspirc_pkg::OFF_CTRL};
  assign pslverr = psel && penable && !mapped;

  // Software-visible registers.
  logic [9:0] ctrl_q; // Port control register.
  logic [15:0] divInt_q; // Integer divisor staging register.
  logic [5:0] divisor_fraction_field_q; // Fraction divisor staging register.
  logic [7:0] lpDiv_q; // Low-power divider, zero means 256.
  aspirc_pkg::aspirc_cfg_t cfg_q; // Active 30-bit configuration.
  logic lineWr; // Line control write this cycle.
  assign lineWr = accWr && paddr == aspirc_pkg::OFF_LINE;

  logic portEn, txEn, rxEn, irEn, irLp; // Control fields.
  assign portEn = ctrl_q[aspirc_pkg::CTRL_PORT_EN];
  assign txEn = ctrl_q[aspirc_pkg::CTRL_TX_EN];
  assign rxEn = ctrl_q[aspirc_pkg::CTRL_RX_EN];
  assign irEn = ctrl_q[aspirc_pkg::CTRL_IR_EN];
  assign irLp = ctrl_q[aspirc_pkg::CTRL_IR_LP];

  // Staging registers load freely; the divisor only takes effect with a line write.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_q <= aspirc_pkg::CTRL_RESET;
      divInt_q <= 16'h0000;
      divisor_fraction_field_q <= 6'h00;
      lpDiv_q <= 8'h00;
      cfg_q <= '0;
    end
    else if (accWr)
    begin
      if (paddr == aspirc_pkg::OFF_CTRL) ctrl_q <= pwdata[9:0];
      if (paddr == aspirc_pkg::OFF_DIVINT) divInt_q <= pwdata[15:0];
      if (paddr == aspirc_pkg::OFF_DIVISOR_FRACTION_FIELD) divisor_fraction_field_q <= pwdata[5:0];
      if (paddr == aspirc_pkg::OFF_LPDIV) lpDiv_q <= pwdata[7:0];
      if (lineWr) cfg_q <= {divInt_q, divisor_fraction_field_q, pwdata[7:0]};
    end
  end

  // Fractional baud generator: period is divInt cycles plus one extra cycle
  // each time the fraction accumulator overflows, so the average is divInt+frac/64.
  logic [16:0] baudCnt_q; // Cycles since the last tick.
  logic [5:0] fracAcc_q; // Fraction accumulator.
  logic extra_q; // Stretch the current period by one cycle.
  logic oversampleTick; // Sixteen times the bit rate.
  logic [6:0] fracSum; // Accumulator plus fraction.
  assign fracSum = {1'b0, fracAcc_q} + {1'b0, cfg_q.divisor_fraction_field};
  assign oversampleTick = cfg_q.divInt != 16'h0000 &&
    baudCnt_q >= {1'b0, cfg_q.divInt} + {16'h0000, extra_q};
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || lineWr)
    begin
      baudCnt_q <= 17'h00001;
      fracAcc_q <= 6'h00;
      extra_q <= 1'b0;
    end
    else if (oversampleTick)
    begin
      baudCnt_q <= 17'h00001;
      fracAcc_q <= fracSum[5:0];
      extra_q <= fracSum[6];
    end
    else baudCnt_q <= baudCnt_q + 17'h00001;
  end

  // Low-power infrared tick: divides the system clock by lpDiv, zero giving 256.
  logic [7:0] lpCnt_q; // Divider count.
  logic lowpowerIrTick; // One cycle per divider period.
  assign lowpowerIrTick = lpCnt_q == lpDiv_q - 8'h01;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || lowpowerIrTick) lpCnt_q <= 8'h00;
    else lpCnt_q <= lpCnt_q + 8'h01;
  end

  // Transmit FIFO, written from the data register.
  logic [7:0] txMem [DEPTH];
  logic [AW:0] txWr_q, txRd_q; // Wrapping pointers.
  logic txFull, txEmpty, txPush, txPop; // FIFO status and strobes.
  assign txFull = fill(txWr_q, txRd_q) == (AW+1)'(DEPTH);
  assign txEmpty = txWr_q == txRd_q;
  assign txPush = accWr && paddr == aspirc_pkg::OFF_DATA && !txFull;

  // Transmit engine state.
  aspirc_pkg::aspirc_tx_t txState_q; // Current frame part.
  logic [3:0] txTick_q; // Oversample ticks within the bit.
  logic [2:0] txBitIdx_q; // Data bit or stop bit index.
  logic [7:0] txShift_q; // Character being sent.
  logic txLine; // Plain serial level.
  logic txBitEnd; // Last tick of a bit.
  logic [1:0] lpPulse_q; // Low-power ticks since bit start.
  logic txPar; // Parity bit to send.
  logic txBusy; // Transmitter busy flag.
  assign txBitEnd = oversampleTick && txTick_q == aspirc_pkg::BIT_LAST_TICK;
  assign txPop = txState_q == aspirc_pkg::TX_IDLE && !txEmpty && portEn && txEn;
  assign txBusy = !txEmpty || txState_q != aspirc_pkg::TX_IDLE;

  // Parity over the enabled data bits; stick parity sends a fixed level.
  function automatic logic parity(input logic [7:0] d, input aspirc_pkg::aspirc_line_t l);
    logic [7:0] m;
    m = 8'h1f | (8'he0 >> (2'h3 - l.wlen));
    if (l.stick) parity = !l.evenPar;
    else parity = ^(d & m) ^ !l.evenPar;
  endfunction
  assign txPar = parity(txShift_q, cfg_q.line);

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) txWr_q <= '0;
    else if (txPush)
    begin
      txMem[txWr_q[AW-1:0]] <= pwdata[7:0];
      txWr_q <= txWr_q + 1'b1;
    end
  end

  // Frame sequencing. The enable is looked at only between characters, so a
  // character under way always completes.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      txState_q <= aspirc_pkg::TX_IDLE;
      txRd_q <= '0;
      txTick_q <= 4'h0;
      txBitIdx_q <= 3'h0;
      txShift_q <= 8'h00;
    end
    else
    begin
      if (oversampleTick) txTick_q <= txTick_q + 4'h1;
      case (txState_q)
        aspirc_pkg::TX_IDLE:
        begin
          if (txPop)
          begin
            txShift_q <= txMem[txRd_q[AW-1:0]];
            txRd_q <= txRd_q + 1'b1;
            txTick_q <= 4'h0;
            txState_q <= aspirc_pkg::TX_START;
          end
        end
        aspirc_pkg::TX_START:
        begin
          if (txBitEnd)
          begin
            txBitIdx_q <= 3'h0;
            txState_q <= aspirc_pkg::TX_DATA;
          end
        end
        aspirc_pkg::TX_DATA:
        begin
          if (txBitEnd)
          begin
            txBitIdx_q <= txBitIdx_q + 3'h1;
            // Data leaves LSB first by index; the copy is never shifted, so the
            // parity worked out from it stays valid for the whole frame.
            if ({1'b0, txBitIdx_q} == {2'b00, cfg_q.line.wlen} + 4'h4)
            begin
              txBitIdx_q <= 3'h0;
              txState_q <= cfg_q.line.parEn ? aspirc_pkg::TX_PAR : aspirc_pkg::TX_STOP;
            end
          end
        end
        aspirc_pkg::TX_PAR:
        begin
          if (txBitEnd) txState_q <= aspirc_pkg::TX_STOP;
        end
        aspirc_pkg::TX_STOP:
        begin
          if (txBitEnd)
          begin
            txBitIdx_q <= 3'h1;
            if (!cfg_q.line.twoStop || txBitIdx_q == 3'h1)
              txState_q <= aspirc_pkg::TX_IDLE;
          end
        end
        default: txState_q <= aspirc_pkg::TX_IDLE;
      endcase
    end
  end

  // Plain line level for each frame part.
  always_comb
  begin
    case (txState_q)
      aspirc_pkg::TX_START: txLine = 1'b0;
      aspirc_pkg::TX_DATA: txLine = txShift_q[txBitIdx_q];
      aspirc_pkg::TX_PAR: txLine = txPar;
      default: txLine = 1'b1;
    endcase
    if (cfg_q.line.sendBreak) txLine = 1'b0;
  end

  // Low-power pulse timer restarts at each bit boundary.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n || txBitEnd || txPop) lpPulse_q <= 2'h0;
    else if (lowpowerIrTick && lpPulse_q != aspirc_pkg::IR_LP_TICKS) lpPulse_q <= lpPulse_q + 2'h1;
  end

  // Infrared encoder: a zero becomes a short high pulse, a one stays low.
  logic irPulse; // Pulse window of the current bit.
  assign irPulse = irLp ? lpPulse_q != aspirc_pkg::IR_LP_TICKS
                        : txTick_q < aspirc_pkg::IR_NORMAL_TICKS;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) serialOutPin <= 1'b1;
    else if (irEn) serialOutPin <= !txLine && irPulse && txState_q != aspirc_pkg::TX_IDLE;
    else serialOutPin <= txLine;
  end

  // Two-flop synchroniser; only the second stage is looked at.
  logic rxMeta_q, rxSync_q; // Synchroniser stages.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rxMeta_q <= 1'b1;
      rxSync_q <= 1'b1;
    end
    else
    begin
      rxMeta_q <= serialInPin;
      rxSync_q <= rxMeta_q;
    end
  end

  // Infrared decoder: a low pulse is stretched to a full zero bit.
  logic [4:0] irHold_q; // Ticks left in a decoded zero.
  logic rxBit; // Decoded serial level.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) irHold_q <= 5'h00;
    else if (irEn && !rxSync_q) irHold_q <= 5'h10;
    else if (oversampleTick && irHold_q != 5'h00) irHold_q <= irHold_q - 5'h01;
  end
  assign rxBit = irEn ? irHold_q == 5'h00 : rxSync_q;

  // Receive FIFO holding status above the character.
  logic [11:0] rxMem [DEPTH];
  logic [AW:0] rxWr_q, rxRd_q; // Wrapping pointers.
  logic rxFull, rxEmpty, rxPush, rxPop; // FIFO status and strobes.
  assign rxFull = fill(rxWr_q, rxRd_q) == (AW+1)'(DEPTH);
  assign rxEmpty = rxWr_q == rxRd_q;
  assign rxPop = accRd && paddr == aspirc_pkg::OFF_DATA && !rxEmpty;

  // Receive engine.
  aspirc_pkg::aspirc_rx_t rxState_q; // Current frame part.
  logic [3:0] rxTick_q; // Ticks within the bit.
  logic [2:0] rxBitIdx_q; // Data bits taken.
  logic [7:0] rxShift_q; // Character gathered.
  logic rxParErr_q; // Parity mismatch seen.
  logic rxAllLow_q; // Every sample so far was low.
  logic overrunPend_q; // A character was lost; mark the next one.
  logic [11:0] pushWord; // Entry written at the stop bit.
  logic rxSample; // Middle of a bit.
  assign rxSample = oversampleTick && rxTick_q == aspirc_pkg::BIT_LAST_TICK;
  assign rxPush = rxSample && rxState_q == aspirc_pkg::RX_STOP;
  assign pushWord = {overrunPend_q, rxAllLow_q && !rxBit, rxParErr_q, !rxBit,
    rxShift_q >> (2'h3 - cfg_q.line.wlen)};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rxState_q <= aspirc_pkg::RX_IDLE;
      rxWr_q <= '0;
      rxTick_q <= 4'h0;
      rxBitIdx_q <= 3'h0;
      rxShift_q <= 8'h00;
      rxParErr_q <= 1'b0;
      rxAllLow_q <= 1'b0;
      overrunPend_q <= 1'b0;
    end
    else
    begin
      if (oversampleTick) rxTick_q <= rxTick_q + 4'h1;
      case (rxState_q)
        aspirc_pkg::RX_IDLE:
        begin
          rxTick_q <= 4'h0;
          if (portEn && rxEn && !rxBit) rxState_q <= aspirc_pkg::RX_START;
        end
        aspirc_pkg::RX_START:
        begin
          if (oversampleTick && rxTick_q == aspirc_pkg::START_CHECK_TICK)
          begin
            rxTick_q <= 4'h0;
            rxBitIdx_q <= 3'h0;
            rxParErr_q <= 1'b0;
            rxAllLow_q <= 1'b1;
            // A high level here was noise: drop it back to idle.
            rxState_q <= rxBit ? aspirc_pkg::RX_IDLE : aspirc_pkg::RX_DATA;
          end
        end
        aspirc_pkg::RX_DATA:
        begin
          if (rxSample)
          begin
            rxShift_q <= {rxBit, rxShift_q[7:1]};
            rxAllLow_q <= rxAllLow_q && !rxBit;
            rxBitIdx_q <= rxBitIdx_q + 3'h1;
            if ({1'b0, rxBitIdx_q} == {2'b00, cfg_q.line.wlen} + 4'h4)
              rxState_q <= cfg_q.line.parEn ? aspirc_pkg::RX_PAR : aspirc_pkg::RX_STOP;
          end
        end
        aspirc_pkg::RX_PAR:
        begin
          if (rxSample)
          begin
            rxParErr_q <= rxBit != parity(rxShift_q >> (2'h3 - cfg_q.line.wlen),
              cfg_q.line);
            rxAllLow_q <= rxAllLow_q && !rxBit;
            rxState_q <= aspirc_pkg::RX_STOP;
          end
        end
        aspirc_pkg::RX_STOP:
        begin
          if (rxSample)
          begin
            rxState_q <= aspirc_pkg::RX_IDLE;
            if (rxFull) overrunPend_q <= 1'b1;
            else
            begin
              rxMem[rxWr_q[AW-1:0]] <= pushWord;
              rxWr_q <= rxWr_q + 1'b1;
              overrunPend_q <= 1'b0;
            end
          end
        end
        default: rxState_q <= aspirc_pkg::RX_IDLE;
      endcase
    end
  end

  // Receive status: error bits of the last read entry plus sticky overrun and
  // false start. A write clears them, but a new event in that cycle still sets.
  logic [4:0] rxStat_q; // {false start, overrun, break, parity, framing}.
  logic falseStart; // Start check found the line high.
  assign falseStart = rxState_q == aspirc_pkg::RX_START && oversampleTick &&
    rxTick_q == aspirc_pkg::START_CHECK_TICK && rxBit;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) rxStat_q <= 5'h00;
    else
    begin
      if (accWr && paddr == aspirc_pkg::OFF_RXSTAT) rxStat_q <= 5'h00;
      if (rxPop) rxStat_q[2:0] <= rxMem[rxRd_q[AW-1:0]][10:8];
      if (rxPush && rxFull) rxStat_q[3] <= 1'b1;
      if (falseStart) rxStat_q[aspirc_pkg::ST_START] <= 1'b1;
    end
  end

  // Receive read pointer.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) rxRd_q <= '0;
    else if (rxPop) rxRd_q <= rxRd_q + 1'b1;
  end

  // Read data is registered in the setup cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n) prdata <= 32'h00000000;
    else if (setupRd)
    begin
      case (paddr)
        aspirc_pkg::OFF_DATA: prdata <= rxEmpty ? 32'h00000000
                                      : {20'h00000, rxMem[rxRd_q[AW-1:0]]};
        aspirc_pkg::OFF_RXSTAT: prdata <= {27'h0, rxStat_q};
        aspirc_pkg::OFF_FLAG: prdata <= {24'h000000, txEmpty, rxFull, txFull, rxEmpty,
                                         txBusy, 3'h0};
        aspirc_pkg::OFF_LPDIV: prdata <= {24'h000000, lpDiv_q};
        aspirc_pkg::OFF_DIVINT: prdata <= {16'h0000, divInt_q};
        aspirc_pkg::OFF_DIVISOR_FRACTION_FIELD: prdata <= {26'h0, divisor_fraction_field_q};
        aspirc_pkg::OFF_LINE: prdata <= {24'h000000, cfg_q.line};
        aspirc_pkg::OFF_CTRL: prdata <= {22'h0, ctrl_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_cfg_load;
    !lineWr |=> $stable(cfg_q);
  endproperty
  a_cfg_load: assert property (p_cfg_load) else $error("config moved without line write");

  // Busy may only drop at the end of a stop bit, never in mid-frame.
  property p_busy;
    txBusy && !(txState_q == aspirc_pkg::TX_STOP && txBitEnd) |=> txBusy;
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped before stop bit end");

  property p_start_low;
    txState_q == aspirc_pkg::TX_START && !irEn |=> !serialOutPin;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low");

  property p_false_start;
    falseStart |=> rxState_q == aspirc_pkg::RX_IDLE ##0 rxStat_q[aspirc_pkg::ST_START];
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not dropped");

  property p_tx_gate;
    txState_q == aspirc_pkg::TX_IDLE && !(portEn && txEn) |=> txState_q == aspirc_pkg::TX_IDLE;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("transmit began while disabled");

  property p_ir_idle;
    irEn && txState_q == aspirc_pkg::TX_IDLE ##1 irEn |-> !serialOutPin;
  endproperty
  a_ir_idle: assert property (p_ir_idle) else $error("infrared idle not low");

  property p_frame_err;
    rxPush && !rxFull && !rxBit |=> rxMem[rxWr_q[AW-1:0] - 1'b1][aspirc_pkg::ST_FRAME];
  endproperty
  a_frame_err: assert property (p_frame_err) else $error("framing error missed");

  property p_rx_store;
    rxPush && !rxFull |=> rxWr_q == $past(rxWr_q) + 1'b1;
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("character not stored");

  property p_sync;
    ##2 rxSync_q == $past(serialInPin, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("synchroniser delay wrong");

endmodule

// ### aspirc_pkg.sv
package aspirc_pkg;

  // Register byte offsets on the APB side.
  localparam logic [11:0] OFF_DATA = 12'h000;
  localparam logic [11:0] OFF_RXSTAT = 12'h004;
  localparam logic [11:0] OFF_FLAG = 12'h018;
  localparam logic [11:0] OFF_LPDIV = 12'h020;
  localparam logic [11:0] OFF_DIVINT = 12'h024;
  localparam logic [11:0] OFF_DIVISOR_FRACTION_FIELD = 12'h028;
  localparam logic [11:0] OFF_LINE = 12'h02c;
  localparam logic [11:0] OFF_CTRL = 12'h030;

  // Control register field positions and reset value.
  localparam int CTRL_PORT_EN = 0;
  localparam int CTRL_IR_EN = 1;
  localparam int CTRL_IR_LP = 2;
  localparam int CTRL_TX_EN = 8;
  localparam int CTRL_RX_EN = 9;
  localparam logic [9:0] CTRL_RESET = 10'h300;

  // Flag register field positions.
  localparam int FLAG_BUSY = 3;
  localparam int FLAG_RX_EMPTY = 4;
  localparam int FLAG_TX_FULL = 5;
  localparam int FLAG_RX_FULL = 6;
  localparam int FLAG_TX_EMPTY = 7;

  // Receive status positions inside a 12-bit receive entry; ST_START is a bit of the receive status register.
  localparam int ST_FRAME = 8;
  localparam int ST_PARITY = 9;
  localparam int ST_BREAK = 10;
  localparam int ST_OVERRUN = 11;
  localparam int ST_START = 4;

  // Oversampling figures: check point of the start bit, last tick of a bit and infrared pulse lengths.
  localparam logic [3:0] START_CHECK_TICK = 4'h7;
  localparam logic [3:0] BIT_LAST_TICK = 4'hf;
  localparam logic [3:0] IR_NORMAL_TICKS = 4'h3;
  localparam logic [1:0] IR_LP_TICKS = 2'h3;

  // Line control layout, low byte of the line control register.
  typedef struct packed {
    logic stick;      // Bit 7: stick parity.
    logic [1:0] wlen; // Bits 6:5: data bits minus five.
    logic fifoEn;     // Bit 4: kept for software, FIFOs are always on.
    logic twoStop;    // Bit 3: two stop bits.
    logic evenPar;    // Bit 2: even parity.
    logic parEn;      // Bit 1: parity enable.
    logic sendBreak;  // Bit 0: hold the line low.
  } aspirc_line_t;

  // The 30-bit configuration loaded on a line control write.
  typedef struct packed {
    logic [15:0] divInt;
    logic [5:0] divisor_fraction_field;
    aspirc_line_t line;
  } aspirc_cfg_t;

  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} aspirc_tx_t;
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} aspirc_rx_t;

endpackage

// ### aspirc_remote.sv
`timescale 1ns/1ps

// Far-end serial device: sends frames on demand and captures received frames.
module aspirc_remote #(
  parameter int BIT = 16 // Clocks per bit.
) (
  input wire logic clk_sys, // Bench clock.
  input wire logic lineIn, // Line driven by the port.
  output logic lineOut // Line into the port.
);
  logic [7:0] got [4]; // Captured characters.
  int nGot = 0; // Count of captured characters.

  initial lineOut = 1'b1;

  // Start bit, eight data bits LSB first, then one stop bit at a chosen level.
  // In infrared form a zero is a short low light pulse and a one leaves the line high.
  task automatic send(input logic [7:0] ch, input logic stopLvl, input logic ir);
    logic [9:0] fr;
    fr = {stopLvl, ch, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      lineOut <= fr[i];
      if (ir && !fr[i])
      begin
        repeat (3) @(posedge clk_sys);
        lineOut <= 1'b1;
        repeat (BIT - 3) @(posedge clk_sys);
      end
      else repeat (BIT) @(posedge clk_sys);
    end
    lineOut <= 1'b1; // Idle line rests high.
    repeat (BIT) @(posedge clk_sys);
  endtask

  // Mid-bit capture of each frame that the port sends.
  initial
  begin
    forever
    begin
      @(negedge lineIn);
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT) @(posedge clk_sys);
        got[nGot % 4][i] = lineIn;
      end
      repeat (BIT) @(posedge clk_sys);
      nGot++;
    end
  end
endmodule

// ### async_serial_port_with_ir_codec_bench.sv
`timescale 1ns/1ps

// Bench: registers over APB, frames checked against the far-end model.
module async_serial_port_with_ir_codec_bench;
  logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, rxLine, txLine;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] seed = 8'h39; // Seed 57.
  logic [7:0] c0, c1;
  logic err; // Slave error seen in the access phase.
  int n_mismatch = 0;
  int checked = 0;

  aspirc_core u_aspirc_core (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serialInPin(rxLine), .serialOutPin(txLine));
  aspirc_remote u_aspirc_remote (.clk_sys(clk_sys), .lineIn(txLine), .lineOut(rxLine));

  // Next pseudo-random byte.
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Fraction field for clock rate f and bit rate b: fraction of f/(16b), times 64, rounded.
  function automatic logic [5:0] frac_field(input longint f, input longint b);
    return 6'((f * 128 / (16 * b) + 1) / 2);
  endfunction

  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // One APB transfer; held until pready is seen high in the access phase.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Compares one register value.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict;
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: whole run is about a thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, aspirc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", {22'h0, aspirc_pkg::CTRL_RESET}, rd);
    chk("okay", 32'h0, 32'(err));
    apb(1'b0, aspirc_pkg::OFF_FLAG, 32'h0);
    chk("flag", 32'h90, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("slverr", 32'h1, 32'(err));
    // Port is still off here, so reprogramming is allowed.
    apb(1'b1, aspirc_pkg::OFF_DIVINT, 32'h1);
    apb(1'b1, aspirc_pkg::OFF_DIVISOR_FRACTION_FIELD, {26'h0, frac_field(64'h17d7840, 64'h17d784)});
    apb(1'b1, aspirc_pkg::OFF_LINE, 32'h60);
    apb(1'b1, aspirc_pkg::OFF_CTRL, 32'h301);
    c0 = lfsr(seed);
    c1 = lfsr(c0);
    apb(1'b1, aspirc_pkg::OFF_DATA, {24'h0, c0});
    apb(1'b1, aspirc_pkg::OFF_DATA, {24'h0, c1});
    apb(1'b0, aspirc_pkg::OFF_FLAG, 32'h0);
    chk("busy", 32'h1, 32'(rd[aspirc_pkg::FLAG_BUSY]));
    wait (u_aspirc_remote.nGot == 2);
    chk("tx0", {24'h0, c0}, {24'h0, u_aspirc_remote.got[0]});
    chk("tx1", {24'h0, c1}, {24'h0, u_aspirc_remote.got[1]});
    repeat (40) @(posedge clk_sys);
    apb(1'b0, aspirc_pkg::OFF_FLAG, 32'h0);
    chk("idle", 32'h90, rd);
    u_aspirc_remote.send(c1, 1'b1, 1'b0);
    u_aspirc_remote.send(8'h55, 1'b0, 1'b0);
    repeat (40) @(posedge clk_sys);
    apb(1'b0, aspirc_pkg::OFF_DATA, 32'h0);
    chk("rx", {24'h0, c1}, rd);
    apb(1'b0, aspirc_pkg::OFF_DATA, 32'h0);
    chk("frame", 32'h155, rd);
    // The low stop bit is seen as a fresh start, which then fails its check.
    apb(1'b0, aspirc_pkg::OFF_RXSTAT, 32'h0);
    chk("rxstat", 32'h11, rd);
    apb(1'b1, aspirc_pkg::OFF_RXSTAT, 32'h0);
    apb(1'b0, aspirc_pkg::OFF_RXSTAT, 32'h0);
    chk("rxclear", 32'h0, rd);
    // Infrared receive; the port is switched off before its control changes.
    apb(1'b1, aspirc_pkg::OFF_CTRL, 32'h300);
    apb(1'b1, aspirc_pkg::OFF_CTRL, 32'h303);
    // Transmitter is long quiet; the gap is shortened to keep the run brief.
    repeat (40) @(posedge clk_sys);
    u_aspirc_remote.send(c0, 1'b1, 1'b1);
    repeat (40) @(posedge clk_sys);
    apb(1'b0, aspirc_pkg::OFF_DATA, 32'h0);
    chk("irrx", {24'h0, c0}, rd);
    give_verdict();
  end
endmodule
